//--- src/pirq_pkg.sv
package pirq_pkg;
    // ======================================================
    // register offsets are word indices; byte address is four times the index
    localparam logic [7:0] IDX_FLAGS_1     = 8'h0C;
    localparam logic [7:0] IDX_FLAGS_2     = 8'h0D;
    localparam logic [7:0] IDX_ENABLES_1   = 8'h8C;
    localparam logic [7:0] IDX_ENABLES_2   = 8'h8D;
    localparam logic [7:0] IDX_POWER_STAT  = 8'h8E;
    localparam logic [7:0] IDX_IRQ_CONTROL = 8'h8B;
    localparam logic [7:0] IDX_EVENT_SRC   = 8'hF0;
    // ======================================================
    // field positions
    localparam int BIT_CONV        = 6;
    localparam int BIT_SERIAL      = 3;
    localparam int BIT_CAPCMP      = 2;
    localparam int BIT_PERIOD      = 1;
    localparam int BIT_OVERFLOW    = 0;
    localparam int BIT_LOW_VOLTAGE = 7;
    localparam int BIT_COLLISION   = 3;
    localparam int BIT_OSC_SPEED   = 3;
    localparam int BIT_POWER_ON    = 1;
    localparam int BIT_BROWNOUT    = 0;
    localparam int BIT_GLOBAL_EN   = 7;
    localparam int BIT_PERIPH_EN   = 6;
    // ======================================================
    // implemented-bit masks and reset values
    localparam logic [7:0] MASK_1       = 8'h4F;
    localparam logic [7:0] MASK_2       = 8'h88;
    localparam logic [7:0] MASK_POWER   = 8'h0B;
    localparam logic [7:0] MASK_CONTROL = 8'hC0;
    localparam logic [7:0] RST_ZERO     = 8'h00;
    localparam logic       RST_OSC      = 1'b1;
    // ======================================================
    // capture/compare unit modes
    typedef enum logic [1:0] {
        CCP_CAPTURE = 2'h0,
        CCP_COMPARE = 2'h1,
        CCP_PWM     = 2'h2,
        CCP_OFF     = 2'h3
    } ccp_mode_e;
    // oscillator modes
    typedef enum logic [1:0] {
        OSC_INTERNAL_RC = 2'h0,
        OSC_EXT_RES     = 2'h1,
        OSC_OTHER       = 2'h2
    } osc_mode_e;
endpackage

//--- src/sticky_flag.sv
`timescale 1ns/100ps
module sticky_flag (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic set_pulse,
    input  wire logic clr_pulse,
    input  wire logic wr_pulse,
    input  wire logic wr_value,
    output logic      flag_q
);
    logic flag_d;

    // hardware set outranks a software clear in the same cycle
    assign flag_d = set_pulse ? 1'b1 : (wr_pulse ? wr_value : (clr_pulse ? 1'b0 : flag_q));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    a_set_wins : assert property (@(posedge pclk) disable iff (!presetn)
        set_pulse |=> flag_q)
        else $error("flag lost a set");
endmodule

//--- src/peripheral_irq_flags_reset_status.sv
// How it works
// - conversion done sets flag bit 6
// - serial transfer done sets flag bit 3
// - master start/stop/restart/ack completion sets bit 3
// - idle start seen sets serial flag
// - idle stop seen sets serial flag
// - capture event sets bit 2 in capture mode
// - compare match sets bit 2 in compare mode; unused in pwm
// - period match sets bit 1
// - sixteen bit timer rollover sets bit 0
// - flags bits 7,5,4 read zero, ignore writes
// - flags set regardless of any enable
// - enables two: bit 7 and 3, reset zero
// - low supply sets flags two bit 7
// - master collision sets flags two bit 3
// - speed bit resets one; rc fast or slow
// - resistor mode speed select; else ignored
// - power-on reset clears bit 1 only
// - brownout reset clears brownout status bit
// - brownout status undefined after power-on
// - power-on status tells reset kinds apart
// - peripheral irq needs peripheral and global enable
// - enables one mirror flags one bit positions
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
module peripheral_irq_flags_reset_status (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        conversion_done,
    input  wire logic        serial_transfer_done,
    input  wire logic        master_sequence_done,
    input  wire logic        idle_start_seen,
    input  wire logic        idle_stop_seen,
    input  wire logic        capture_event,
    input  wire logic        compare_match,
    input  wire logic [1:0]  ccp_mode,
    input  wire logic        period_match,
    input  wire logic        timer_rollover,
    input  wire logic        low_voltage_event,
    input  wire logic        collision_event,
    input  wire logic        power_on_event,
    input  wire logic        brownout_event,
    input  wire logic        brownout_detector_enable,
    input  wire logic [1:0]  osc_mode,
    output logic             peripheral_irq,
    output logic             slow_clock_select
);
    // ======================================================
    // apb decode
    logic       apb_access;
    logic       wr_en;
    logic       addr_ok;
    logic [9:0] word_idx;
    logic       hit_f1;
    logic       hit_f2;
    logic       hit_e1;
    logic       hit_e2;
    logic       hit_pw;
    logic       hit_ic;
    logic       hit_ev;

    function automatic logic hit(input logic [9:0] idx, input logic [7:0] reg_idx);
        hit = (idx == {2'h0, reg_idx});
    endfunction

    assign apb_access = psel && penable && pready;
    assign word_idx   = paddr[11:2];
    assign hit_f1     = hit(word_idx, pirq_pkg::IDX_FLAGS_1);
    assign hit_f2     = hit(word_idx, pirq_pkg::IDX_FLAGS_2);
    assign hit_e1     = hit(word_idx, pirq_pkg::IDX_ENABLES_1);
    assign hit_e2     = hit(word_idx, pirq_pkg::IDX_ENABLES_2);
    assign hit_pw     = hit(word_idx, pirq_pkg::IDX_POWER_STAT);
    assign hit_ic     = hit(word_idx, pirq_pkg::IDX_IRQ_CONTROL);
    assign hit_ev     = hit(word_idx, pirq_pkg::IDX_EVENT_SRC);
    assign addr_ok    = (paddr[1:0] == 2'h0)
                        && (hit_f1 || hit_f2 || hit_e1 || hit_e2 || hit_pw || hit_ic || hit_ev);
    assign wr_en      = apb_access && pwrite && addr_ok;

    // ======================================================
    // event pins come from other logic; sync them anyway as they may be asynchronous
    localparam int NEV = 12;
    logic [NEV-1:0] ev_raw;
    logic [NEV-1:0] ev_s1_q;
    logic [NEV-1:0] ev_s2_q;
    logic [NEV-1:0] ev_s3_q;
    logic [NEV-1:0] ev_rise;
    logic [3:0]     mode_s1_q;
    logic [3:0]     mode_s2_q;
    logic           brownout_detector_enable_s1_q;
    logic           brownout_detector_enable_s2_q;

    assign ev_raw = {brownout_event, power_on_event, collision_event, low_voltage_event,
                     timer_rollover, period_match, compare_match, capture_event,
                     idle_stop_seen, idle_start_seen, master_sequence_done,
                     serial_transfer_done};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_s1_q    <= '0;
            ev_s2_q    <= '0;
            ev_s3_q    <= '0;
            mode_s1_q  <= 4'h0;
            mode_s2_q  <= 4'h0;
            brownout_detector_enable_s1_q <= 1'b0;
            brownout_detector_enable_s2_q <= 1'b0;
        end else begin
            ev_s1_q    <= ev_raw;
            ev_s2_q    <= ev_s1_q;
            ev_s3_q    <= ev_s2_q;
            mode_s1_q  <= {osc_mode, ccp_mode};
            mode_s2_q  <= mode_s1_q;
            brownout_detector_enable_s1_q <= brownout_detector_enable;
            brownout_detector_enable_s2_q <= brownout_detector_enable_s1_q;
        end
    end

    // edge detect so a held level sets a flag once, not again after a clear
    assign ev_rise = ev_s2_q & ~ev_s3_q;

    logic conv_sync_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_sync_q <= 1'b0;
        end else begin
            conv_sync_q <= conversion_done;
        end
    end
    logic conv_s2_q;
    logic conv_s3_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_s2_q <= 1'b0;
            conv_s3_q <= 1'b0;
        end else begin
            conv_s2_q <= conv_sync_q;
            conv_s3_q <= conv_s2_q;
        end
    end

    // ======================================================
    // set terms, independent of every enable
    logic [7:0] set_1;
    logic [7:0] set_2;
    logic       serial_set;
    logic       capcmp_set;
    pirq_pkg::ccp_mode_e ccp_m;

    assign ccp_m      = pirq_pkg::ccp_mode_e'(mode_s2_q[1:0]);
    assign serial_set = ev_rise[0]
                        || ev_rise[1]
                        || ev_rise[2]
                        || ev_rise[3];
    assign capcmp_set = (ccp_m == pirq_pkg::CCP_CAPTURE && ev_rise[4])
                        || (ccp_m == pirq_pkg::CCP_COMPARE && ev_rise[5]);

    assign set_1 = {1'b0, conv_s2_q & ~conv_s3_q, 2'b00, serial_set, capcmp_set,
                    ev_rise[6], ev_rise[7]};
    assign set_2 = {ev_rise[8], 3'b000, ev_rise[9], 3'b000};

    // ======================================================
    // flag registers, masked to implemented bits
    logic [7:0] flags_1;
    logic [7:0] flags_2;
    logic [7:0] wr_1;
    logic [7:0] wr_2;

    assign wr_1 = {8{wr_en && hit_f1}} & pirq_pkg::MASK_1;
    assign wr_2 = {8{wr_en && hit_f2}} & pirq_pkg::MASK_2;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_flags
            if (pirq_pkg::MASK_1[gi]) begin : g_f1
                sticky_flag u_flag (
                    .pclk      (pclk),
                    .presetn   (presetn),
                    .set_pulse (set_1[gi]),
                    .clr_pulse (1'b0),
                    .wr_pulse  (wr_1[gi]),
                    .wr_value  (pwdata[gi]),
                    .flag_q    (flags_1[gi])
                );
            end else begin : g_z1
                assign flags_1[gi] = 1'b0;
            end
            if (pirq_pkg::MASK_2[gi]) begin : g_f2
                sticky_flag u_flag (
                    .pclk      (pclk),
                    .presetn   (presetn),
                    .set_pulse (set_2[gi]),
                    .clr_pulse (1'b0),
                    .wr_pulse  (wr_2[gi]),
                    .wr_value  (pwdata[gi]),
                    .flag_q    (flags_2[gi])
                );
            end else begin : g_z2
                assign flags_2[gi] = 1'b0;
            end
        end
    endgenerate

    // ======================================================
    // enables, control and power status
    logic [7:0] en1_q;
    logic [7:0] en2_q;
    logic [7:0] ctl_q;
    logic       osc_q;
    logic       por_q;
    logic       bor_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en1_q <= pirq_pkg::RST_ZERO;
            en2_q <= pirq_pkg::RST_ZERO;
            ctl_q <= pirq_pkg::RST_ZERO;
            osc_q <= pirq_pkg::RST_OSC;
        end else begin
            if (wr_en && hit_e1) en1_q <= pwdata[7:0] & pirq_pkg::MASK_1;
            if (wr_en && hit_e2) en2_q <= pwdata[7:0] & pirq_pkg::MASK_2;
            if (wr_en && hit_ic) ctl_q <= pwdata[7:0] & pirq_pkg::MASK_CONTROL;
            if (wr_en && hit_pw) osc_q <= pwdata[pirq_pkg::BIT_OSC_SPEED];
        end
    end

    // bus reset doubles as power-on reset, so both status bits start clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_q <= 1'b0;
            bor_q <= 1'b0;
        end else begin
            if (ev_rise[10]) begin
                por_q <= 1'b0;
            end else if (wr_en && hit_pw) begin
                por_q <= pwdata[pirq_pkg::BIT_POWER_ON];
            end
            if (ev_rise[11] && brownout_detector_enable_s2_q) begin
                bor_q <= 1'b0;
            end else if (wr_en && hit_pw) begin
                bor_q <= pwdata[pirq_pkg::BIT_BROWNOUT];
            end
        end
    end

    // ======================================================
    // interrupt and oscillator select
    logic irq_d;
    logic slow_d;
    pirq_pkg::osc_mode_e osc_m;

    assign irq_d = ctl_q[pirq_pkg::BIT_GLOBAL_EN] && ctl_q[pirq_pkg::BIT_PERIPH_EN]
                   && (|(flags_1 & en1_q) || |(flags_2 & en2_q));
    assign osc_m  = pirq_pkg::osc_mode_e'(mode_s2_q[3:2]);
    // rc and resistor modes: zero picks the slow clock; other modes ignore the bit
    assign slow_d = ((osc_m == pirq_pkg::OSC_INTERNAL_RC)
                     || (osc_m == pirq_pkg::OSC_EXT_RES)) && !osc_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_irq    <= 1'b0;
            slow_clock_select <= 1'b0;
        end else begin
            peripheral_irq    <= irq_d;
            slow_clock_select <= slow_d;
        end
    end

    // ======================================================
    // read mux and apb answer
    logic [7:0] rd_byte;
    assign rd_byte = hit_f1 ? flags_1 :
                     hit_f2 ? flags_2 :
                     hit_e1 ? en1_q :
                     hit_e2 ? en2_q :
                     hit_ic ? ctl_q :
                     hit_pw ? {4'h0, osc_q, 1'b0, por_q, bor_q} :
                     hit_ev ? {6'h00, ccp_m == pirq_pkg::CCP_PWM, brownout_detector_enable_s2_q} : 8'h00;

    // no wait states: setup, access, ready high in first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata  <= (psel && !penable && !pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
        end
    end

    // ======================================================
    // checks
    a_irq_gated : assert property (@(posedge pclk) disable iff (!presetn)
        !ctl_q[pirq_pkg::BIT_PERIPH_EN] |=> !peripheral_irq)
        else $error("irq without peripheral enable");
    a_pad_zero : assert property (@(posedge pclk) disable iff (!presetn)
        (flags_1 & ~pirq_pkg::MASK_1) == 8'h00)
        else $error("unimplemented flag bit set");
    a_ovf_sets : assert property (@(posedge pclk) disable iff (!presetn)
        ev_rise[7] |=> flags_1[pirq_pkg::BIT_OVERFLOW])
        else $error("overflow flag not set");
    a_period_sets : assert property (@(posedge pclk) disable iff (!presetn)
        ev_rise[6] |=> flags_1[pirq_pkg::BIT_PERIOD])
        else $error("period flag not set");
    a_serial_sets : assert property (@(posedge pclk) disable iff (!presetn)
        serial_set |=> flags_1[pirq_pkg::BIT_SERIAL])
        else $error("serial flag not set");
    a_pwm_quiet : assert property (@(posedge pclk) disable iff (!presetn)
        (ccp_m == pirq_pkg::CCP_PWM) |-> !capcmp_set)
        else $error("capture flag set in pwm");
    a_por_clears : assert property (@(posedge pclk) disable iff (!presetn)
        ev_rise[10] |=> !por_q)
        else $error("power-on status not cleared");
    a_lv_sets : assert property (@(posedge pclk) disable iff (!presetn)
        ev_rise[8] |=> flags_2[pirq_pkg::BIT_LOW_VOLTAGE])
        else $error("low voltage flag not set");
endmodule

//--- testbench/event_source_model.sv
`timescale 1ns/100ps
module event_source_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        fire,
    input  wire logic [12:0] req,
    output logic      [12:0] ev
);
    // ==================================================
    // event pulses
    // each event stands three cycles so the two-flop synchroniser cannot miss it
    logic [1:0] cnt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev    <= 13'h0000;
            cnt_q <= 2'h0;
        end else if (fire) begin
            ev    <= req;
            cnt_q <= 2'h3;
        end else if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
            if (cnt_q == 2'h1) begin
                ev <= 13'h0000;
            end
        end
    end
endmodule

//--- testbench/tb.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin fail_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module tb;
    // ==================================================
    // signals
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, fire;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [12:0] req, ev;
    logic [1:0]  ccp_mode, osc_mode;
    logic        bod_en, irq, slow, er;
    int          fail_count, n_compared;
    logic [7:0]  regs [6], rstv [6], msk [6], evreg [11], evbit [11];
    logic [7:0]  f1, e1, f2, e2, ct;

    peripheral_irq_flags_reset_status uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conversion_done(ev[0]), .serial_transfer_done(ev[1]), .master_sequence_done(ev[2]),
        .idle_start_seen(ev[3]), .idle_stop_seen(ev[4]), .capture_event(ev[5]),
        .compare_match(ev[6]), .ccp_mode(ccp_mode), .period_match(ev[7]),
        .timer_rollover(ev[8]), .low_voltage_event(ev[9]), .collision_event(ev[10]),
        .power_on_event(ev[11]), .brownout_event(ev[12]),
        .brownout_detector_enable(bod_en), .osc_mode(osc_mode),
        .peripheral_irq(irq), .slow_clock_select(slow)
    );
    event_source_model src (.pclk(pclk), .presetn(presetn), .fire(fire), .req(req), .ev(ev));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // ==================================================
    // tasks
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a transfer that never gets an answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd      = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic fire_ev(input int i);
        @(posedge pclk);
        req  <= 13'h0001 << i;
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
        // flag shows 3-4 cycles after the edge; wait well past it
        repeat (8) @(posedge pclk);
    endtask

    function automatic logic exp_irq(input logic [7:0] fa, ea, fb, eb, ctl);
        return ctl[7] && ctl[6] && ((|(fa & ea & 8'h4F)) || (|(fb & eb & 8'h88)));
    endfunction

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        stop_test;
    end

    // ==================================================
    // sequence
    initial begin
        {psel, penable, pwrite, fire, bod_en} = 5'h00;
        {paddr, pwdata, req} = '0;
        ccp_mode = pirq_pkg::CCP_CAPTURE;
        osc_mode = pirq_pkg::OSC_INTERNAL_RC;
        fail_count = 0;
        n_compared = 0;
        presetn = 1'b0;
        void'($urandom(32'h56A3));
        regs = '{pirq_pkg::IDX_FLAGS_1, pirq_pkg::IDX_FLAGS_2, pirq_pkg::IDX_ENABLES_1,
                 pirq_pkg::IDX_ENABLES_2, pirq_pkg::IDX_IRQ_CONTROL, pirq_pkg::IDX_POWER_STAT};
        rstv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08};
        msk  = '{8'h4F, 8'h88, 8'h4F, 8'h88, 8'hC0, 8'h0B};
        evreg = '{8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h0D, 8'h0D};
        evbit = '{8'h40, 8'h08, 8'h08, 8'h08, 8'h08, 8'h04, 8'h04, 8'h02, 8'h01, 8'h80, 8'h08};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        `CHK("irq after reset", 1'b0, irq)
        for (int k = 0; k < 6; k++) begin
            apb(1'b0, regs[k], 8'h00);
            `CHK("reset value", {24'h000000, rstv[k]}, rd)
        end
        // unimplemented bits read zero and ignore writes
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, regs[k], 8'hFF);
            apb(1'b0, regs[k], 8'h00);
            `CHK("mask", {24'h000000, msk[k]}, rd)
            apb(1'b1, regs[k], (k == 5) ? 8'h0B : 8'h00);
        end
        apb(1'b0, 8'h00, 8'h00);
        `CHK("unmapped", 33'h100000000, {er, rd})
        // every flag event sets its flag with all enables off
        for (int i = 0; i < 11; i++) begin
            ccp_mode <= (i == 6) ? pirq_pkg::CCP_COMPARE : pirq_pkg::CCP_CAPTURE;
            apb(1'b1, pirq_pkg::IDX_FLAGS_1, 8'h00);
            apb(1'b1, pirq_pkg::IDX_FLAGS_2, 8'h00);
            fire_ev(i);
            apb(1'b0, evreg[i], 8'h00);
            `CHK("event flag", {24'h000000, evbit[i]}, rd)
            `CHK("no irq", 1'b0, irq)
        end
        // pwm mode leaves the capture/compare flag alone
        apb(1'b1, pirq_pkg::IDX_FLAGS_1, 8'h00);
        ccp_mode <= pirq_pkg::CCP_PWM;
        fire_ev(6);
        apb(1'b0, pirq_pkg::IDX_FLAGS_1, 8'h00);
        `CHK("pwm flag", 32'h00000000, rd)
        apb(1'b0, pirq_pkg::IDX_EVENT_SRC, 8'h00);
        `CHK("pwm mode seen", 32'h00000002, rd)
        // random flag and enable mixes against the request line
        for (int j = 0; j < 12; j++) begin
            f1 = $urandom & 8'hFF;
            e1 = $urandom & 8'hFF;
            f2 = $urandom & 8'hFF;
            e2 = $urandom & 8'hFF;
            ct = (j < 3) ? 8'h40 << j : $urandom & 8'hFF;
            apb(1'b1, pirq_pkg::IDX_FLAGS_1, f1);
            apb(1'b1, pirq_pkg::IDX_FLAGS_2, f2);
            apb(1'b1, pirq_pkg::IDX_ENABLES_1, e1);
            apb(1'b1, pirq_pkg::IDX_ENABLES_2, e2);
            if (j >= 3) ct = ct | 8'hC0;
            apb(1'b1, pirq_pkg::IDX_IRQ_CONTROL, ct);
            repeat (2) @(posedge pclk);
            `CHK("irq", exp_irq(f1, e1, f2, e2, ct), irq)
        end
        // reset kind status bits; a brownout with the detector off is ignored
        fire_ev(12);
        apb(1'b0, pirq_pkg::IDX_POWER_STAT, 8'h00);
        `CHK("brownout ignored", 32'h0000000B, rd)
        bod_en <= 1'b1;
        fire_ev(11);
        apb(1'b0, pirq_pkg::IDX_POWER_STAT, 8'h00);
        `CHK("power-on status", 32'h00000009, rd)
        fire_ev(12);
        apb(1'b0, pirq_pkg::IDX_POWER_STAT, 8'h00);
        `CHK("brownout status", 32'h00000008, rd)
        // speed bit against oscillator mode
        for (int m = 0; m < 3; m++) begin
            osc_mode <= m[1:0];
            apb(1'b1, pirq_pkg::IDX_POWER_STAT, 8'h03);
            repeat (2) @(posedge pclk);
            `CHK("slow clock", (m < 2) ? 1'b1 : 1'b0, slow)
            apb(1'b1, pirq_pkg::IDX_POWER_STAT, 8'h0B);
            repeat (2) @(posedge pclk);
            `CHK("fast clock", 1'b0, slow)
        end
        stop_test;
    end
endmodule
